// ==== logic/eeh_ctrl.sv ====
// Bus controller that drives a two-wire serial EEPROM through its pins
`timescale 1ns/1ps
// ==========================================================
// Overview of operation
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Data changes only while clock low
// - Recovery: up to nine clocks, then start
// - Device word with type pattern follows start
// - Last address bit: one reads, zero writes
// - Write: two address bytes, data, stop
// - Page write: up to 127 further bytes
// - Poll with device word until acknowledged
// - Current read: no acknowledge, then stop
// - Random read: dummy write, repeated start
// - Sequential read: acknowledge each, last withheld
module eeh_ctrl #(
  parameter int         PROG_CYC = eeh_pkg::PROG_CYC,
  parameter logic [4:0] DEV_TYPE = eeh_pkg::DEV_TYPE_DEF
) (
  // Clock and reset
  input  logic              sys_clk,
  input  logic              rst_n,
  // Command
  input  logic              cmd_valid,
  output logic              cmd_ready,
  input  eeh_pkg::eeh_cmd_t cmd,
  // Write data
  input  logic              wdata_valid,
  output logic              wdata_ready,
  input  logic [7:0]        wdata,
  // Read data and status
  output logic              rdata_valid,
  output logic [7:0]        rdata,
  output eeh_pkg::eeh_rsp_t rsp,
  output logic              busy,
  // Bus pins
  input  logic              scl_i,
  output logic              scl_o,
  output logic              scl_oe,
  input  logic              sda_i,
  output logic              sda_o,
  output logic              sda_oe
);
  import eeh_pkg::*;

  typedef enum {
    ST_IDLE, ST_START_SU, ST_START_HD, ST_LOW, ST_HIGH, ST_WAIT_W,
    ST_RS_LOW, ST_STOP_LOW, ST_STOP_SU, ST_BUF
  } eeh_st_t;

  typedef enum {
    BK_DEVW, BK_AH, BK_AL, BK_WDATA, BK_DEVR, BK_RDATA, BK_REC
  } eeh_kind_t;

  localparam int PW = $clog2(PROG_CYC + 1);

  eeh_st_t          st_q;
  eeh_st_t          st_d;
  eeh_kind_t        kind_q;
  eeh_op_t          op_q;
  logic [1:0]       sel_q;
  logic [15:0]      addr_q;
  logic [7:0]       len_q;
  logic [7:0]       sh_q;
  logic [7:0]       rdata_q;
  logic [3:0]       bit_q;
  logic [TMR_W-1:0] tmr_q;
  logic [PW-1:0]    poll_tmr_q;
  logic             poll_q;
  logic             err_q;
  logic             done_q;
  logic             rvalid_q;
  logic             scl_oe_q;
  logic             sda_oe_q;
  logic [1:0]       pin_s;
  logic             scl_s;
  logic             sda_s;
  logic             tick;
  logic             tdone;
  logic             hi_end;
  logic             ack_bit;
  logic             byte_end;
  logic             acked;
  logic             more;
  logic             accept;

  // ==========================================================
  // Pin sampling
  eeh_sync #(.W(2)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d_i     ({scl_i, sda_i}),
    .q_o     (pin_s)
  );

  assign scl_s    = pin_s[1];
  assign sda_s    = pin_s[0];
  // Released clock counts only once seen high, so stretching is honoured
  assign tick     = scl_oe_q | scl_s;
  assign tdone    = (tmr_q == '0) && tick;
  assign hi_end   = (st_q == ST_HIGH) && tdone;
  assign ack_bit  = (bit_q == 4'(BYTE_BITS));
  assign byte_end = hi_end && ack_bit && (kind_q != BK_REC);
  assign acked    = ~sda_s;
  assign more     = (len_q != '0);
  assign accept   = (st_q == ST_IDLE) && cmd_valid;

  function automatic logic [TMR_W-1:0] tmr_load(eeh_st_t s);
    case (s)
      ST_START_SU: return TMR_W'(CYC_SU_STA);
      // One extra cycle: data pin moves a cycle after the state
      ST_START_HD: return TMR_W'(CYC_HD_STA + 1);
      ST_LOW:      return TMR_W'(CYC_LOW);
      ST_HIGH:     return TMR_W'(CYC_HIGH);
      ST_RS_LOW:   return TMR_W'(CYC_LOW);
      ST_STOP_LOW: return TMR_W'(CYC_LOW);
      ST_STOP_SU:  return TMR_W'(CYC_SU_STO);
      ST_BUF:      return TMR_W'(CYC_BUF + 1);
      default:     return '0;
    endcase
  endfunction

  // ==========================================================
  // Sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (cmd_valid) begin
          st_d = (cmd.op == EEH_OP_RECOVER) ? ST_LOW : ST_START_SU;
        end
      end
      ST_START_SU: if (tdone) st_d = ST_START_HD;
      ST_START_HD: begin
        if (tdone) begin
          st_d = (kind_q == BK_REC) ? ST_STOP_LOW : ST_LOW;
        end
      end
      ST_LOW: if (tdone) st_d = ST_HIGH;
      ST_HIGH: begin
        if (tdone) begin
          if (kind_q == BK_REC) begin
            if (sda_s) begin
              st_d = ST_START_SU;
            end else if (bit_q == 4'(REC_CLOCKS - 1)) begin
              st_d = ST_IDLE;
            end else begin
              st_d = ST_LOW;
            end
          end else if (!ack_bit) begin
            st_d = ST_LOW;
          end else begin
            case (kind_q)
              BK_DEVW:        st_d = (acked && !poll_q) ? ST_LOW : ST_STOP_LOW;
              BK_AH, BK_DEVR: st_d = acked ? ST_LOW : ST_STOP_LOW;
              BK_AL: begin
                if (!acked) begin
                  st_d = ST_STOP_LOW;
                end else if (op_q == EEH_OP_WRITE) begin
                  st_d = ST_WAIT_W;
                end else begin
                  st_d = ST_RS_LOW;
                end
              end
              BK_WDATA: st_d = (acked && more) ? ST_WAIT_W : ST_STOP_LOW;
              BK_RDATA: st_d = more ? ST_LOW : ST_STOP_LOW;
              default:  st_d = ST_STOP_LOW;
            endcase
          end
        end
      end
      ST_WAIT_W:   if (wdata_valid) st_d = ST_LOW;
      ST_RS_LOW:   if (tdone) st_d = ST_START_SU;
      ST_STOP_LOW: if (tdone) st_d = ST_STOP_SU;
      ST_STOP_SU:  if (tdone) st_d = ST_BUF;
      ST_BUF: begin
        if (tdone) begin
          st_d = (poll_q && poll_tmr_q != '0) ? ST_START_SU : ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= '0;
    end else if (st_d != st_q) begin
      tmr_q <= tmr_load(st_d);
    end else if (tick && tmr_q != '0) begin
      tmr_q <= tmr_q - 1'b1;
    end
  end

  // ==========================================================
  // Transfer bookkeeping
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q   <= EEH_OP_WRITE;
      sel_q  <= '0;
      addr_q <= '0;
      len_q  <= '0;
    end else if (accept) begin
      op_q   <= cmd.op;
      sel_q  <= cmd.sel;
      addr_q <= cmd.addr;
      // A page takes at most one byte plus 127 more
      len_q  <= (cmd.op == EEH_OP_WRITE && cmd.count > 8'(PAGE_BYTES - 1)) ?
                8'(PAGE_BYTES - 1) : cmd.count;
    end else if (byte_end && more && (kind_q == BK_WDATA || kind_q == BK_RDATA)) begin
      len_q <= len_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_q <= BK_DEVW;
    end else if (accept) begin
      case (cmd.op)
        EEH_OP_RECOVER:  kind_q <= BK_REC;
        EEH_OP_READ_CUR: kind_q <= BK_DEVR;
        default:         kind_q <= BK_DEVW;
      endcase
    end else if (byte_end) begin
      case (kind_q)
        BK_DEVW: kind_q <= BK_AH;
        BK_AH:   kind_q <= BK_AL;
        BK_AL:   kind_q <= (op_q == EEH_OP_WRITE) ? BK_WDATA : BK_DEVR;
        BK_DEVR: kind_q <= BK_RDATA;
        default: kind_q <= kind_q;
      endcase
    end else if (st_q == ST_BUF && st_d == ST_START_SU) begin
      kind_q <= BK_DEVW;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= '0;
    end else if (accept) begin
      sh_q <= {DEV_TYPE, cmd.sel,
               (cmd.op == EEH_OP_READ_CUR) ? RW_READ : RW_WRITE};
    end else if (st_q == ST_WAIT_W && wdata_valid) begin
      sh_q <= wdata;
    end else if (st_q == ST_BUF && st_d == ST_START_SU) begin
      sh_q <= {DEV_TYPE, sel_q, RW_WRITE};
    end else if (byte_end) begin
      case (kind_q)
        BK_DEVW: sh_q <= addr_q[15:8];
        BK_AH:   sh_q <= addr_q[7:0];
        BK_AL:   sh_q <= {DEV_TYPE, sel_q, RW_READ};
        default: sh_q <= sh_q;
      endcase
    end else if (hi_end) begin
      sh_q <= {sh_q[6:0], sda_s};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= '0;
    end else if (accept) begin
      bit_q <= '0;
    end else if (hi_end) begin
      bit_q <= (ack_bit && kind_q != BK_REC) ? 4'h0 : bit_q + 4'h1;
    end
  end

  // ==========================================================
  // Acknowledge polling across the programming cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      poll_q     <= 1'b0;
      poll_tmr_q <= '0;
    end else if (byte_end && kind_q == BK_WDATA && acked && !more) begin
      poll_q <= 1'b1;
    end else begin
      // Time runs from the stop, as the device counts it
      if (poll_q && kind_q == BK_WDATA && st_q == ST_STOP_SU && st_d == ST_BUF) begin
        poll_tmr_q <= PW'(PROG_CYC);
      end else if (poll_tmr_q != '0) begin
        poll_tmr_q <= poll_tmr_q - 1'b1;
      end
      if ((byte_end && kind_q == BK_DEVW && acked) || (st_q == ST_BUF && st_d == ST_IDLE)) begin
        poll_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (accept) begin
      err_q <= 1'b0;
    end else if (byte_end && !acked && kind_q != BK_RDATA && !(poll_q && kind_q == BK_DEVW)) begin
      err_q <= 1'b1;
    end else if (hi_end && kind_q == BK_REC && !sda_s && bit_q == 4'(REC_CLOCKS - 1)) begin
      err_q <= 1'b1;
    end else if (st_q == ST_BUF && tdone && poll_q && poll_tmr_q == '0) begin
      err_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q   <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end else begin
      done_q   <= (st_q != ST_IDLE) && (st_d == ST_IDLE);
      rvalid_q <= hi_end && kind_q == BK_RDATA && bit_q == 4'(BYTE_BITS - 1);
      if (hi_end && kind_q == BK_RDATA && bit_q == 4'(BYTE_BITS - 1)) begin
        rdata_q <= {sh_q[6:0], sda_s};
      end
    end
  end

  // ==========================================================
  // Pin drive
  // Data lags the clock by a cycle so it never moves while clock is high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= st_d inside {ST_LOW, ST_WAIT_W, ST_RS_LOW, ST_STOP_LOW};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        ST_START_HD, ST_STOP_LOW, ST_STOP_SU: sda_oe_q <= 1'b1;
        ST_LOW: begin
          if (kind_q == BK_REC) begin
            sda_oe_q <= 1'b0;
          end else if (ack_bit) begin
            sda_oe_q <= (kind_q == BK_RDATA) && more;
          end else begin
            sda_oe_q <= (kind_q != BK_RDATA) && !sh_q[7];
          end
        end
        ST_HIGH, ST_WAIT_W: sda_oe_q <= sda_oe_q;
        default: sda_oe_q <= 1'b0;
      endcase
    end
  end

  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign scl_oe      = scl_oe_q;
  assign sda_oe      = sda_oe_q;
  assign cmd_ready   = (st_q == ST_IDLE);
  assign busy        = (st_q != ST_IDLE);
  assign wdata_ready = (st_q == ST_WAIT_W);
  assign rdata_valid = rvalid_q;
  assign rdata       = rdata_q;
  assign rsp         = '{done: done_q, err: err_q};

  // ==========================================================
  // Checks
  AST_START_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(sda_oe_q) && !scl_oe_q |-> st_q == ST_START_HD)
    else $error("data pulled low with clock high outside a start");

  AST_STOP_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(sda_oe_q) && !scl_oe_q |-> st_q == ST_BUF && $past(st_q, 2) == ST_STOP_SU)
    else $error("data released with clock high outside a stop");

  AST_DATA_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(sda_oe_q) |-> scl_oe_q || st_q inside {ST_START_HD, ST_BUF})
    else $error("data moved while clock released");

  AST_DEV_WORD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == ST_START_HD && st_d == ST_LOW |=> sh_q[7:3] == DEV_TYPE && bit_q == 4'h0)
    else $error("byte after start is not a device word");

  AST_DIR_BIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == ST_START_HD && st_d == ST_LOW |-> sh_q[0] == (kind_q == BK_DEVR))
    else $error("direction bit does not match the transfer");

  AST_REC_BOUND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == ST_HIGH && kind_q == BK_REC |-> bit_q < 4'(REC_CLOCKS))
    else $error("recovery ran past nine clocks");

  AST_RD_ACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == ST_HIGH && kind_q == BK_RDATA && ack_bit |-> sda_oe_q == (len_q != '0))
    else $error("read acknowledge does not follow remaining count");

  AST_WR_STOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    byte_end && kind_q == BK_WDATA && len_q == '0 |=> st_q == ST_STOP_LOW ##1 sda_oe_q)
    else $error("last write byte not followed by a stop");

  AST_POLL_END: assert property (@(posedge sys_clk) disable iff (!rst_n)
    byte_end && kind_q == BK_DEVW && poll_q && acked |=> st_q == ST_STOP_LOW && !poll_q)
    else $error("acknowledged poll did not close the wait");

  AST_RAND_RS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    byte_end && kind_q == BK_AL && acked && op_q == EEH_OP_READ_RAND
    |=> st_q == ST_RS_LOW && kind_q == BK_DEVR ##1 !sda_oe_q)
    else $error("random read missed its repeated start");

  AST_PAGE_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    kind_q == BK_WDATA |-> len_q < 8'(PAGE_BYTES))
    else $error("write burst longer than one page");

endmodule

// ==== logic/eeh_pkg.sv ====
// Package: bus timing, framing constants and carrier types of the EEPROM controller
package eeh_pkg;

  // ==========================================================
  // Bus timing, nanoseconds and milliseconds as printed, then whole cycles
  localparam int CLK_NS          = 25;
  localparam int T_LOW_NS        = 4700;
  localparam int T_HIGH_NS       = 4000;
  localparam int T_SU_STA_NS     = 4700;
  localparam int T_HD_STA_NS     = 4000;
  localparam int T_SU_STO_NS     = 4700;
  localparam int T_BUF_NS        = 4700;
  localparam int PROG_TIME_MS    = 10;
  localparam int PROG_TIME_LV_MS = 20;

  // Least times round up
  localparam int CYC_LOW    = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_HIGH   = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_SU_STA = (T_SU_STA_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_HD_STA = (T_HD_STA_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_SU_STO = (T_SU_STO_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_BUF    = (T_BUF_NS + CLK_NS - 1) / CLK_NS;
  // Longest wait for programming, slowest grade, rounds down
  localparam int PROG_TIME_WORST_MS =
    (PROG_TIME_LV_MS > PROG_TIME_MS) ? PROG_TIME_LV_MS : PROG_TIME_MS;
  localparam int PROG_CYC = PROG_TIME_WORST_MS * 1000000 / CLK_NS;
  localparam int TMR_W    = 8;

  // ==========================================================
  // Framing
  localparam int         REC_CLOCKS   = 9;
  localparam int         BYTE_BITS    = 8;
  localparam int         PAGE_BYTES   = 128;
  localparam logic [4:0] DEV_TYPE_DEF = 5'h14;
  localparam logic       RW_READ      = 1'b1;
  localparam logic       RW_WRITE     = 1'b0;

  // ==========================================================
  // Carrier types
  typedef enum logic [1:0] {
    EEH_OP_WRITE,
    EEH_OP_READ_CUR,
    EEH_OP_READ_RAND,
    EEH_OP_RECOVER
  } eeh_op_t;

  typedef struct packed {
    eeh_op_t     op;
    logic [1:0]  sel;
    logic [15:0] addr;
    logic [7:0]  count;
  } eeh_cmd_t;

  typedef struct packed {
    logic done;
    logic err;
  } eeh_rsp_t;

endpackage

// ==== logic/eeh_sync.sv ====
// Two-flop synchroniser for the bus pin levels
`timescale 1ns/1ps
module eeh_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  logic         sys_clk,
  input  logic         rst_n,
  // Levels
  input  logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // Idle bus level is high, so both stages reset high
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q[i] <= 1'b1;
        q_o[i]    <= 1'b1;
      end else begin
        meta_q[i] <= d_i[i];
        q_o[i]    <= meta_q[i];
      end
    end
  end

endmodule

// ==== tb/eeh_mem_model.sv ====
// Behavioural two-wire serial EEPROM on the far side of the controller
`timescale 1ns/1ps
module eeh_mem_model #(
  parameter logic [4:0] DEV_TYPE = 5'h14,
  parameter int         PROG_NS  = 100000
) (
  // Bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull,
  // Straps
  input  wire logic [1:0] strap,
  input  wire logic       lock
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  sh;
  logic [7:0]  ob;
  logic [15:0] cnt;
  logic        act, rd, mack, wrote, prog;
  int          ph, nb;

  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    {act, rd, mack, wrote, prog, sda_pull} = '0;
    cnt = '0;
    ph = 0;
    nb = 0;
  end

  // ==========================================================
  // Start, stop and programming cycle
  always @(negedge sda) begin
    if (scl) begin
      act = !prog;
      rd = 1'b0;
      ph = 0;
      nb = 0;
      wrote = 1'b0;
      sda_pull = 1'b0;
    end
  end

  always @(posedge sda) begin
    if (scl) begin
      act = 1'b0;
      if (wrote)
        prog = 1'b1;
    end
  end

  always begin
    @(posedge prog);
    #(PROG_NS);
    prog = 1'b0;
  end

  // ==========================================================
  // Bits: sample on rising clock, shift out on falling clock
  always @(posedge scl) begin
    if (act) begin
      ph = ph + 1;
      if (ph <= 8)
        sh = {sh[6:0], sda};
      else
        mack = !sda;
    end
  end

  task automatic take_byte;
    if (nb == 0) begin
      // Floating straps read as low
      if (sh[7:3] == DEV_TYPE && sh[2:1] == {strap[1] === 1'b1, strap[0] === 1'b1}) begin
        rd = sh[0];
        sda_pull = 1'b1;
      end else
        act = 1'b0;
    end else begin
      sda_pull = 1'b1;
      if (nb == 1)
        cnt[15:8] = sh;
      else if (nb == 2)
        cnt[7:0] = sh;
      else begin
        if (lock !== 1'b1) begin
          mem[cnt] = sh;
          wrote = 1'b1;
        end
        cnt[6:0] = cnt[6:0] + 7'h01;
      end
    end
  endtask

  always @(negedge scl) begin
    if (act && ph == 8) begin
      sda_pull = 1'b0;
      if (!(rd && nb > 0))
        take_byte();
    end else if (act && ph == 9) begin
      ph = 0;
      nb = nb + 1;
      sda_pull = 1'b0;
      if (rd && (nb == 1 || mack)) begin
        ob = mem[cnt];
        cnt = cnt + 16'h0001;
        sda_pull = !ob[7];
      end else if (rd)
        act = 1'b0;
    end else if (act && rd && nb > 0)
      sda_pull = !ob[7 - ph];
  end
endmodule

// ==== tb/tb_serial_eeprom_two_wire_target.sv ====
// Self-checking bench for the two-wire EEPROM controller
`timescale 1ns/1ps
module tb_serial_eeprom_two_wire_target;
  import eeh_pkg::*;
  localparam logic [4:0] DEV_TYPE = 5'h14;
  localparam int         MAX_CYC  = 100000;

  logic       sys_clk, rst_n, cmd_valid, wdata_valid, lock;
  logic       cmd_ready, wdata_ready, rdata_valid, busy;
  logic       scl_o, scl_oe, sda_o, sda_oe, sda_pull;
  logic [7:0] wdata, rdata, b;
  logic [1:0] strap;
  eeh_cmd_t   cmd;
  eeh_rsp_t   rsp;
  int         err_count, check_count, cyc, seed;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  logic [7:0] mir [int];
  // Pulled-up wires: released lines read high
  wire        scl_w = !scl_oe;
  wire        sda_w = !(sda_oe || sda_pull);

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = !sys_clk;

  eeh_ctrl #(.PROG_CYC(20000), .DEV_TYPE(DEV_TYPE)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata),
    .rdata_valid(rdata_valid), .rdata(rdata), .rsp(rsp), .busy(busy),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));

  eeh_mem_model #(.DEV_TYPE(DEV_TYPE), .PROG_NS(100000)) mem_u (
    .scl(scl_w), .sda(sda_w), .sda_pull(sda_pull), .strap(strap), .lock(lock));

  // ==========================================================
  // Comparison and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [7:0] exp_at(input logic [15:0] a);
    return mir.exists(a) ? mir[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
  endfunction

  task automatic run_cmd(input eeh_op_t op, input logic [1:0] s, input logic [15:0] a,
                         input logic [7:0] n, input logic e);
    @(posedge sys_clk);
    cmd <= '{op, s, a, n};
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    while (cmd_ready !== 1'b1)
      @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(posedge sys_clk);
    check({7'h00, busy}, 8'h01);
    while (rsp.done !== 1'b1)
      @(posedge sys_clk);
    check({7'h00, rsp.err}, {7'h00, e});
    check(8'(rq.size()), 8'h00);
    check(8'(wq.size()) | {7'h00, wdata_valid}, 8'h00);
  endtask

  // ==========================================================
  // Write-byte supply, read-byte compare, time limit
  always @(posedge sys_clk) begin
    if (wdata_valid && wdata_ready)
      wdata_valid <= 1'b0;
    else if (!wdata_valid && wq.size() > 0) begin
      wdata <= wq.pop_front();
      wdata_valid <= 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (rdata_valid === 1'b1) begin
      check({7'h00, rq.size() > 0}, 8'h01);
      if (rq.size() > 0)
        check(rdata, rq.pop_front());
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == MAX_CYC) begin
      err_count++;
      $display("FAIL %0t: run did not finish", $time);
      stop_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h4089B7AD;
    {rst_n, cmd_valid, wdata_valid, lock} = '0;
    cmd = '0;
    wdata = '0;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    strap = 2'($random(seed));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check({2'h0, scl_o, sda_o, busy, cmd_ready, scl_oe, sda_oe}, 8'h04);
    run_cmd(EEH_OP_RECOVER, strap, 16'h0000, 8'h00, 1'b0);
    // Two bytes from the page end: the second lands at the page start
    for (int i = 0; i < 2; i++) begin
      b = 8'($random(seed));
      wq.push_back(b);
      mir[{9'h000, 7'(7'h7F + i)}] = b;
    end
    run_cmd(EEH_OP_WRITE, strap, 16'h007F, 8'h01, 1'b0);
    rq.push_back(exp_at(16'hFFFF));
    rq.push_back(exp_at(16'h0000));
    run_cmd(EEH_OP_READ_RAND, strap, 16'hFFFF, 8'h01, 1'b0);
    rq.push_back(exp_at(16'h0001));
    run_cmd(EEH_OP_READ_CUR, strap, 16'h0000, 8'h00, 1'b0);
    run_cmd(EEH_OP_WRITE, ~strap, 16'h0000, 8'h00, 1'b1);
    lock <= 1'b1;
    wq.push_back(~exp_at(16'h0005));
    run_cmd(EEH_OP_WRITE, strap, 16'h0005, 8'h00, 1'b0);
    lock <= 1'b0;
    rq.push_back(exp_at(16'h0005));
    run_cmd(EEH_OP_READ_RAND, strap, 16'h0005, 8'h00, 1'b0);
    stop_test();
  end
endmodule
